// ==== design/cidc_pkg.sv ====
// Purpose: shared constants and types for the cartridge identifier checker
// Assumes: one identifier byte per strobe from the reading logic, idle cycles allowed between bytes
// Notes:   hash body is a fold of the serial, see parameters below
// Operation
// - four eight-byte records; trace type 2 also uses the hash of the last serial record
// - serial: family byte, 48-bit LSB-first serial
// - serial CRC8 reflected 0x8c against byte 7
// - trace type 1: 0x81, main/sub big endian
// - trace/type-sum: inverted byte sum check
// - trace type 2: 0x82, zero tail, hash
// - hash only over serial bytes 1 to 6
// - hash width selectable, 16 or 14
// - type byte 0..2, bytes 1-6 zero
// - all-zero type record valid, flagged distinctly
// - pairing record checked like serial record
// - all-zero pairing record means unpaired
// - pairing serial versus board serial mismatch flag
// - pairing value as two four-digit decimal groups
package cidc_pkg;

  localparam logic [7:0]  CIDC_CRC_POLY   = 8'h8c;     // serial_crc_polynomial
  localparam logic [7:0]  CIDC_TRACE_ONE  = 8'h81;     // trace id type 1 code
  localparam logic [7:0]  CIDC_TRACE_TWO  = 8'h82;     // trace id type 2 code
  localparam logic [7:0]  CIDC_TYPE_MAX   = 8'h02;     // largest cartridge type
  localparam logic [7:0]  CIDC_SUM_INV    = 8'hff;     // checksum inversion mask
  localparam logic [2:0]  CIDC_LAST_BYTE  = 3'h7;      // index of check byte
  localparam logic [15:0] CIDC_HASH_MASK14 = 16'h3fff; // 14-bit hash mask
  localparam logic [47:0] CIDC_DEC_GROUP  = 48'h2710;  // 10000, one decimal group
  localparam logic [13:0] CIDC_DEC_1000   = 14'h3e8;   // digit weights
  localparam logic [13:0] CIDC_DEC_100    = 14'h64;
  localparam logic [13:0] CIDC_DEC_10     = 14'ha;

  // identifier record kinds, chosen by the reading logic per record
  typedef enum logic [1:0] {
    CIDC_KIND_SERIAL = 2'b00,
    CIDC_KIND_TRACE  = 2'b01,
    CIDC_KIND_TYPE   = 2'b10,
    CIDC_KIND_PAIR   = 2'b11
  } cidc_kind_t;

  // incoming byte stream
  typedef struct packed {
    logic       valid;  // byte strobe
    cidc_kind_t kind;   // record kind, sampled with byte 0
    logic [7:0] data;   // identifier byte
  } cidc_byte_t;

  // configuration levels
  typedef struct packed {
    logic        hashWidth14;  // hash_width_setting: 1 = 14 bits
    logic        hashBigEnd;   // 1 = hash high byte in byte 1
    logic [47:0] boardSerial;  // serial of attached i/o board
  } cidc_cfg_t;

  // per-record results, all registered
  typedef struct packed {
    logic        done;         // one-cycle pulse after byte 7
    logic        pass;         // record accepted
    logic        fail;         // record rejected
    cidc_kind_t  kind;         // kind of finished record
    logic        traceTypeTwo; // trace record was type 2
    logic        zeroType;     // all-zero type record
    logic        unpaired;     // all-zero pairing record
    logic        mismatch;     // pairing serial differs from board
    logic [7:0]  family;       // serial family code
    logic [47:0] serial;       // serial number, LSB-first assembled
    logic [15:0] mainSerial;   // trace type 1 main serial
    logic [31:0] subSerial;    // trace type 1 sub serial
    logic [7:0]  typeCode;     // cartridge type byte
    logic [15:0] hash;         // hash of last serial record
    logic [15:0] groupLow;     // four bcd digits
    logic [15:0] groupHigh;    // four bcd digits
  } cidc_result_t;

endpackage : cidc_pkg

// ==== design/cidc_checker.sv ====
// Purpose: check and decode cartridge identifier records
// Assumes: reading logic holds kind steady with byte 0, one byte per strobe
// Notes:   results update only on the done pulse and hold until the next one
`timescale 1ns/1ps
module cidc_checker
  import cidc_pkg::*;
(
  input  wire logic         clk_sys,   // 10 MHz system clock
  input  wire logic         arst_n,    // async reset, active low
  input  wire cidc_byte_t   inByte,    // byte stream from the reader
  input  wire cidc_cfg_t    cfg,       // configuration levels
  output cidc_result_t      result     // registered record results
);

  // one packed struct keeps every flop in a single register process
  // bytes 0-6 are kept so the judgement can look at all of them at once
  // whole module state
  typedef struct packed {
    logic [2:0]      idx;     // byte index in current record
    cidc_kind_t      kind;    // kind latched at byte 0
    logic [7:0]      crc;     // running crc over bytes 0-6
    logic [7:0]      sum;     // running sum over bytes 0-6
    logic [6:0][7:0] bytes;   // stored bytes 0-6
    cidc_result_t    res;     // outputs
  } cidc_state_t;

  // st_nxt is filled by the single combinational process below
  // and loaded into st_r on every edge
  cidc_state_t st_r;   // registered state
  cidc_state_t st_nxt; // next state

  // the loop unrolls into an eight-stage xor chain per byte;
  // one byte a clock keeps that chain short enough for 10 MHz
  // reflected crc8, one byte, bits lsb first
  function automatic logic [7:0] cidcCrcByte(input logic [7:0] crcIn, input logic [7:0] val);
    logic [7:0] c;
    logic [7:0] v;
    c = crcIn;
    v = val;
    // bit order follows the wire: lsb of each byte first
    for (int b = 0; b < 8; b++) begin
      if ((c[0] ^ v[0]) == 1'b1) begin
        c = (c >> 1) ^ CIDC_CRC_POLY;
      end else begin
        c = c >> 1;
      end
      v = v >> 1;
    end
    return c;
  endfunction : cidcCrcByte

  // divisions by constants; the operand is below 10000 so each
  // quotient digit fits its four bits
  // binary below 10000 to four bcd digits
  function automatic logic [15:0] cidcBcd(input logic [13:0] v);
    logic [13:0] d3;
    logic [13:0] d2;
    logic [13:0] d1;
    logic [13:0] d0;
    d3 = v / CIDC_DEC_1000;
    d2 = (v / CIDC_DEC_100) % CIDC_DEC_10;
    d1 = (v / CIDC_DEC_10) % CIDC_DEC_10;
    d0 = v % CIDC_DEC_10;
    // only the low nibble of each digit is kept
    return {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
  endfunction : cidcBcd

  // byte 1 ends up in the low bits, byte 6 in the high bits
  // serial bytes 1-6 of a record, least significant first
  function automatic logic [47:0] cidcSerial(input logic [6:0][7:0] b);
    return {b[6], b[5], b[4], b[3], b[2], b[1]};
  endfunction : cidcSerial

  // the real hash body is unknown; this fold stands in for it and
  // keeps the masking and byte order logic exercised
  // limitation: trace records written elsewhere will not match it
  // fold of serial into the trace hash, width chosen by configuration
  function automatic logic [15:0] cidcHash(input logic [47:0] s, input logic w14);
    logic [15:0] h;
    h = s[15:0] ^ s[31:16] ^ s[47:32];
    // 14-bit mode clears the two top bits
    if (w14) begin
      h = h & CIDC_HASH_MASK14;
    end
    return h;
  endfunction : cidcHash

  // the wide dividers sit here too; at 10 MHz the path has room
  // record evaluation and byte accumulation
  always_comb begin
    logic [6:0][7:0] b;
    logic [7:0]      last;
    logic            crcOk;
    logic            sumOk;
    logic            tailZero;
    logic            allZero;
    logic [47:0]     ser;
    logic [47:0]     quot;
    logic [15:0]     expHashBytes;
    cidc_kind_t      k;
    // every local gets a value first so no latch is inferred
    b            = st_r.bytes;
    last         = inByte.data;
    crcOk        = 1'b0;
    sumOk        = 1'b0;
    tailZero     = 1'b0;
    allZero      = 1'b0;
    ser          = '0;
    quot         = '0;
    expHashBytes = '0;
    k            = st_r.kind;
    st_nxt       = st_r;
    st_nxt.res.done = 1'b0; // done is a single pulse
    // nothing moves without a strobe; an idle cycle leaves
    // the partial record and all results but done untouched
    if (inByte.valid) begin
      if (st_r.idx == '0) begin
        // first byte restarts the accumulators
        // kind is latched here and ignored for bytes 1-7
        k           = inByte.kind;
        st_nxt.kind = inByte.kind;
        st_nxt.crc  = cidcCrcByte('0, inByte.data);
        st_nxt.sum  = inByte.data;
      end else if (st_r.idx != CIDC_LAST_BYTE) begin
        // bytes 1-6 extend the running crc and sum
        st_nxt.crc = cidcCrcByte(st_r.crc, inByte.data);
        st_nxt.sum = st_r.sum + inByte.data; // 8-bit wrap on purpose
      end
      if (st_r.idx != CIDC_LAST_BYTE) begin
        // byte 7 is never stored, it is only compared
        st_nxt.bytes[st_r.idx] = inByte.data;
        st_nxt.idx             = st_r.idx + 3'h1;
      end else begin
        // eighth byte: judge the record, idx wraps for the next one
        st_nxt.idx   = '0;
        crcOk        = (st_r.crc == last);
        sumOk        = ((st_r.sum ^ CIDC_SUM_INV) == last);
        tailZero     = ({b[6], b[5], b[4], b[3]} == '0);
        allZero      = (b == '0) && (last == '0);
        ser          = cidcSerial(b);
        // the high decimal group needs the quotient by 10000
        quot         = ser / CIDC_DEC_GROUP;
        st_nxt.res.done         = 1'b1;
        // per-record flags start low so each done reports afresh
        st_nxt.res.kind         = k;
        st_nxt.res.traceTypeTwo = 1'b0;
        st_nxt.res.zeroType     = 1'b0;
        st_nxt.res.unpaired     = 1'b0;
        st_nxt.res.mismatch     = 1'b0;
        st_nxt.res.pass         = 1'b0;
        // per-kind judgement; fields of other kinds keep their values
        case (k)
          CIDC_KIND_SERIAL: begin
            // hash is refreshed even on a bad crc, a later trace check then fails
            st_nxt.res.pass   = crcOk;
            st_nxt.res.family = b[0];
            st_nxt.res.serial = ser;
            st_nxt.res.hash   = cidcHash(ser, cfg.hashWidth14);
          end
          CIDC_KIND_TRACE: begin
            // expected bytes 1-2 in the configured order
            expHashBytes = cfg.hashBigEnd ? st_r.res.hash : {st_r.res.hash[7:0], st_r.res.hash[15:8]};
            // type 2 relies on the serial record that finished last
            if (b[0] == CIDC_TRACE_ONE) begin
              // main serial from bytes 1-2, sub serial from bytes 3-6
              st_nxt.res.pass       = sumOk;
              st_nxt.res.mainSerial = {b[1], b[2]};
              st_nxt.res.subSerial  = {b[3], b[4], b[5], b[6]};
            end else if (b[0] == CIDC_TRACE_TWO) begin
              st_nxt.res.traceTypeTwo = 1'b1;
              st_nxt.res.pass = sumOk && tailZero && ({b[1], b[2]} == expHashBytes);
            end else begin
              st_nxt.res.pass = 1'b0; // unknown trace type
            end
          end
          CIDC_KIND_TYPE: begin
            // the all-zero record is accepted despite its checksum
            if (allZero) begin
              st_nxt.res.pass     = 1'b1;
              st_nxt.res.zeroType = 1'b1;
            end else begin
              // checksum, range of the type byte and zero tail all required
              st_nxt.res.pass = sumOk && (b[0] <= CIDC_TYPE_MAX) && tailZero && (b[2:1] == '0);
            end
            st_nxt.res.typeCode = b[0];
          end
          CIDC_KIND_PAIR: begin
            if (allZero) begin
              st_nxt.res.pass     = 1'b1;
              st_nxt.res.unpaired = 1'b1;
            end else begin
              // crc failure gives fail with mismatch low, never a false mismatch
              st_nxt.res.pass     = crcOk;
              st_nxt.res.mismatch = crcOk && (ser != cfg.boardSerial);
            end
            st_nxt.res.serial    = ser;
            st_nxt.res.groupLow  = cidcBcd(14'(ser % CIDC_DEC_GROUP));
            st_nxt.res.groupHigh = cidcBcd(14'(quot % CIDC_DEC_GROUP));
          end
          default: begin
            // all four kinds are decoded; kept as a safe fallback
            st_nxt.res.pass = 1'b0;
          end
        endcase
        // fail is set as the complement of pass at each judgement, so one flag never lags the other; reset clears both
        st_nxt.res.fail = !st_nxt.res.pass;
      end
    end
  end

  // single state register
  // async reset clears every result, the stored hash as well
  // no clock enable: the register loads on every edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from flops
  assign result = st_r.res;

endmodule : cidc_checker

// ==== verif/cidc_checker_props.sv ====
// Purpose: timing and flag relations at the checker ports
// Assumes: cfg levels stay put while a record is in flight
// Notes:   byte index mirrors the reader stream, wraps at eight
`timescale 1ns/1ps
module cidc_checker_props
  import cidc_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         arst_n,
  input wire cidc_byte_t   inByte,
  input wire cidc_cfg_t    cfg,
  input wire cidc_result_t result
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [2:0] byteIdx_r;  // bytes taken in current record
  // count strobes so a record boundary is known
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) byteIdx_r <= 3'h0;
    else if (inByte.valid) byteIdx_r <= byteIdx_r + 3'h1;
  end
  // eighth byte of a record taken
  sequence lastByte;
    inByte.valid && byteIdx_r == CIDC_LAST_BYTE;
  endsequence
  // finished record that reports a pairing mismatch
  sequence mismatchShown;
    result.done && result.mismatch;
  endsequence
  AST_DONE_AFTER: assert property (lastByte |=> result.done) else $error("done missing");
  AST_DONE_ONLY: assert property (!(inByte.valid && byteIdx_r == CIDC_LAST_BYTE) |=> !result.done)
    else $error("stray done");
  AST_PASS_FAIL: assert property (result.done |-> result.pass != result.fail)
    else $error("pass equals fail");
  AST_HOLD: assert property (!result.done |-> $stable(result.pass) && $stable(result.serial))
    else $error("no hold");
  AST_ZERO_TYPE: assert property (result.zeroType |-> result.pass && result.kind == CIDC_KIND_TYPE)
    else $error("zero type flag");
  AST_UNPAIRED: assert property (result.unpaired |-> result.pass && !result.mismatch)
    else $error("unpaired flag");
  AST_MISMATCH: assert property (mismatchShown |-> result.pass && result.serial != cfg.boardSerial)
    else $error("bad mismatch");
  AST_TYPE_TWO: assert property (result.traceTypeTwo |-> result.kind == CIDC_KIND_TRACE)
    else $error("type two kind");
endmodule : cidc_checker_props

// ==== verif/cidc_reader_model.sv ====
// Purpose: reader side, feeds one identifier record byte by byte
// Assumes: caller waits for the task to return before the next record
// Notes:   idle cycles show scrambled data so stale bytes never look valid
`timescale 1ns/1ps
module cidc_reader_model
  import cidc_pkg::*;
(
  input  wire logic  clk_sys,
  output cidc_byte_t inByte
);
  initial inByte = '0;
  // byte 0 sits in the low eight bits of rec
  task automatic send(input cidc_kind_t k, input logic [63:0] rec, input int gap);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      inByte <= '{1'b1, k, rec[8*i +: 8]};
      // gaps only between bytes, so the task returns while done stands
      if (gap > 0 && i < 7) begin
        @(posedge clk_sys);
        inByte <= '{1'b0, cidc_kind_t'(~k), ~rec[8*i +: 8]};
        repeat (gap - 1) @(posedge clk_sys);
      end
    end
    @(posedge clk_sys);
    inByte <= '{1'b0, cidc_kind_t'(~k), 8'h5a ^ rec[7:0]};
  endtask : send
endmodule : cidc_reader_model

// ==== verif/cidc_checker_tb.sv ====
// Purpose: random and corner records through the identifier checker
// Assumes: hash is the serial fold chosen for the design
// Notes:   cfg only changes between records
`timescale 1ns/1ps
module cidc_checker_tb
  import cidc_pkg::*;
;
  localparam logic [63:0] BAD = {8'h01, 56'h0};  // flips the check byte
  logic clk_sys, arst_n;
  logic [31:0] seed;
  logic [47:0] s, m, p, t;
  logic [15:0] h;
  logic [7:0] f;
  int g, n_mismatch, checks_done;
  cidc_byte_t inByte;
  cidc_cfg_t cfg;
  cidc_result_t result;
  cidc_reader_model rdr (.clk_sys(clk_sys), .inByte(inByte));
  cidc_checker uut (.clk_sys(clk_sys), .arst_n(arst_n), .inByte(inByte), .cfg(cfg), .result(result));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [7:0] crc8(input logic [63:0] r);
    logic [7:0] c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ r[i]) ? (c >> 1) ^ CIDC_CRC_POLY : c >> 1;
    return c;
  endfunction : crc8
  function automatic logic [7:0] sum8(input logic [63:0] r);
    logic [7:0] t = 8'h00;
    for (int i = 0; i < 7; i++) t += r[8*i +: 8];
    return ~t;
  endfunction : sum8
  // record from byte 0, bytes 1-6 and the kind of check byte
  function automatic logic [63:0] rc(input logic [7:0] b0, input logic [47:0] v, input logic crc);
    logic [63:0] r = {8'h00, v, b0};
    r[63:56] = crc ? crc8(r) : sum8(r);
    return r;
  endfunction : rc
  function automatic logic [15:0] hx(input logic [47:0] v);
    logic [15:0] x = v[15:0] ^ v[31:16] ^ v[47:32];
    return cfg.hashWidth14 ? x & CIDC_HASH_MASK14 : x;
  endfunction : hx
  function automatic logic [15:0] bcd(input logic [47:0] v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : bcd
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic run(input cidc_kind_t k, input logic [63:0] r, input logic ok);
    rdr.send(k, r, g);
    #1;
    chk(result.done === 1'b1 && result.pass === ok && result.kind === k, "verdict");
  endtask : run
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // watchdog, far beyond the ~1200 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end
  initial begin
    arst_n = 1'b0;
    cfg = '0;
    seed = 32'h5;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      cfg <= '{i[0], i[1], 48'({rnd(), rnd()})};
      g = i % 3;
      s = 48'({rnd(), rnd()});
      f = 8'(rnd());
      run(CIDC_KIND_SERIAL, rc(f, s, 1'b1) ^ BAD, 1'b0);
      run(CIDC_KIND_SERIAL, rc(f, s, 1'b1), 1'b1);
      chk(result.family === f && result.serial === s && result.hash === hx(s), "serial");
      h = hx(s);
      // hash bytes in the configured order, then in the other order
      t = cfg.hashBigEnd ? {32'h0, h[7:0], h[15:8]} : {32'h0, h};
      run(CIDC_KIND_TRACE, rc(CIDC_TRACE_TWO, t, 1'b0), 1'b1);
      chk(result.traceTypeTwo === 1'b1, "type two");
      t = cfg.hashBigEnd ? {32'h0, h} : {32'h0, h[7:0], h[15:8]};
      run(CIDC_KIND_TRACE, rc(CIDC_TRACE_TWO, t, 1'b0), h[7:0] == h[15:8]);
      run(CIDC_KIND_TRACE, rc(CIDC_TRACE_TWO, {32'h1, h}, 1'b0), 1'b0);
      m = 48'({rnd(), rnd()});
      run(CIDC_KIND_TRACE, rc(CIDC_TRACE_ONE, m, 1'b0), 1'b1);
      chk(result.mainSerial === {m[7:0], m[15:8]}, "main serial");
      chk(result.subSerial === {m[23:16], m[31:24], m[39:32], m[47:40]}, "sub serial");
      run(CIDC_KIND_TRACE, rc(CIDC_TRACE_ONE, m, 1'b0) ^ BAD, 1'b0);
      run(CIDC_KIND_TYPE, rc(8'(i % 4), 48'h0, 1'b0), i % 4 < 3);
      chk(result.typeCode === 8'(i % 4), "type code");
      p = i[0] ? cfg.boardSerial : s;
      run(CIDC_KIND_PAIR, rc(f, p, 1'b1), 1'b1);
      chk(result.mismatch === !i[0], "mismatch");
      chk(result.groupLow === bcd(p % 10000) && result.groupHigh === bcd(p / 10000 % 10000), "pairing");
      $display("test %0d done", i);
    end
    run(CIDC_KIND_TYPE, 64'h0, 1'b1);
    chk(result.zeroType === 1'b1, "zero type");
    run(CIDC_KIND_TYPE, rc(8'h00, 48'h0, 1'b0), 1'b1);
    chk(result.zeroType === 1'b0, "summed zero type");
    run(CIDC_KIND_PAIR, 64'h0, 1'b1);
    chk(result.unpaired === 1'b1 && result.mismatch === 1'b0, "unpaired");
    run(CIDC_KIND_PAIR, rc(f, s, 1'b1) ^ BAD, 1'b0);
    chk(result.mismatch === 1'b0, "bad pairing crc");
    $display("corner tests done");
    summarize();
  end
endmodule : cidc_checker_tb
bind cidc_checker cidc_checker_props chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .inByte(inByte), .cfg(cfg),
  .result(result));
